/* File: rtl/fwec_ctrl.sv */
// Flash write and erase controller with AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fwec_defines.svh"
module fwec_ctrl #(
  parameter int TIMEOUT_CYC = `FWEC_TIMEOUT_CYC,
  parameter int PAGE_BITS = 9,
  parameter logic [31:0] FLASH_SIZE = 32'h0000_8000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output fwec_pkg::fwec_flash_req_t flash_req,
  input wire logic flash_done,
  input wire logic cache_hit,
  input wire logic cache_miss,
  input wire logic irq_pending,
  output logic irq
);
  fwec_pkg::fwec_state_t state;
  fwec_pkg::fwec_status_t st;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [31:0] ctrl_reg;
  logic [31:0] read_setup_reg;
  logic [1:0] write_ctrl;
  logic [31:0] timing_reg;
  logic [31:0] loc_buf;
  logic [31:0] word_buf;
  logic [31:0] target;
  logic [3:0] flags;
  logic [3:0] irq_en;
  logic [`FWEC_CNT_W-1:0] hits;
  logic [`FWEC_CNT_W-1:0] misses;
  logic [31:0] tmo;
  logic [5:0] cmd;
  logic [31:0] next_target;
  logic [31:0] rd_val;
  logic aw_have, w_have, w_strb0, wr_go, wr_cmd, wr_mcmd, op_refused;
  logic multi, sync_a, pend, cfg_locked, unmapped, hit_ovf, miss_ovf;
  logic w_done, e_done, rd_ok;

  // Write channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      aw_addr <= 12'h000;
    end else if (wr_go) begin
      aw_have <= 1'b0;
    end else if (s_awvalid && s_awready) begin
      aw_have <= 1'b1;
      aw_addr <= s_awaddr;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb0 <= 1'b0;
    end else if (wr_go) begin
      w_have <= 1'b0;
    end else if (s_wvalid && s_wready) begin
      w_have <= 1'b1;
      w_data <= s_wdata;
      w_strb0 <= s_wstrb[0];
    end
  end
  assign wr_go = aw_have && w_have && !s_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
    end else begin
      s_awready <= !aw_have && !(s_awvalid && s_awready) && !s_bvalid;
      s_wready <= !w_have && !(s_wvalid && s_wready) && !s_bvalid;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
    end else if (wr_go) begin
      s_bvalid <= 1'b1;
      s_bresp <= 2'h0;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  assign wr_cmd = wr_go && aw_addr == `FWEC_OFF_OP_CMD && !cfg_locked
    && w_strb0;
  assign wr_mcmd = wr_go && aw_addr == `FWEC_OFF_MISC_CMD && w_strb0;
  assign op_refused = wr_go && aw_addr == `FWEC_OFF_OP_CMD && cfg_locked
    && w_strb0 && (w_data[`FWEC_CMD_ERASE] || w_data[`FWEC_CMD_ONCE]
    || w_data[`FWEC_CMD_TRIG]);
  assign cmd = wr_cmd ? w_data[5:0] : 6'h00;
  assign unmapped = loc_buf >= FLASH_SIZE;

  // Protected and plain config registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= 32'h0000_0001;
      read_setup_reg <= 32'h0000_0001;
      timing_reg <= `FWEC_TIMING_RST;
      write_ctrl <= 2'h0;
      loc_buf <= 32'h0000_0000;
      irq_en <= 4'h0;
      cfg_locked <= 1'b0;
    end else if (wr_go) begin
      if (!cfg_locked) begin
        if (aw_addr == `FWEC_OFF_CTRL) ctrl_reg <= {31'h0, w_data[0]};
        if (aw_addr == `FWEC_OFF_READ_SETUP)
          read_setup_reg <= {26'h0, w_data[5:0]};
        if (aw_addr == `FWEC_OFF_TIMING)
          timing_reg <= {15'h0, w_data[16], 10'h0, w_data[5:0]};
      end
      if (aw_addr == `FWEC_OFF_WRITE_CTRL) write_ctrl <= w_data[1:0];
      if (aw_addr == `FWEC_OFF_LOC_BUF) loc_buf <= w_data;
      if (aw_addr == `FWEC_OFF_IRQ_EN) irq_en <= w_data[3:0];
      if (aw_addr == `FWEC_OFF_LOCK)
        cfg_locked <= w_data[15:0] != `FWEC_UNLOCK_KEY;
    end
  end

  // Word buffer and ready flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_buf <= 32'h0000_0000;
      st.word_ready_flag <= 1'b1;
    end else if (wr_go && aw_addr == `FWEC_OFF_WORD_BUF) begin
      word_buf <= w_data;
      st.word_ready_flag <= 1'b0;
    end else if (state == fwec_pkg::FWEC_WRITE && flash_done) begin
      st.word_ready_flag <= 1'b1;
    end
  end

  // Pointer increment with page wrap
  always_comb begin
    next_target = target;
    next_target[PAGE_BITS-1:2] = target[PAGE_BITS-1:2] + 1'b1;
  end

  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= fwec_pkg::FWEC_IDLE;
      target <= 32'h0000_0000;
      multi <= 1'b0;
      tmo <= 32'h0000_0000;
      st.busy <= 1'b0;
      st.invalid_location_flag <= 1'b0;
      st.erase_aborted_flag <= 1'b0;
      st.word_timeout_flag <= 1'b0;
      st.locked <= 1'b0;
      e_done <= 1'b0;
      w_done <= 1'b0;
      sync_a <= 1'b0;
      pend <= 1'b0;
    end else begin
      sync_a <= irq_pending;
      pend <= sync_a;
      e_done <= 1'b0;
      w_done <= 1'b0;
      if (cmd[`FWEC_CMD_LOAD]) begin
        target <= loc_buf;
        st.invalid_location_flag <= unmapped;
      end
      if (cmd[`FWEC_CMD_ERASE] || cmd[`FWEC_CMD_TRIG] ||
          cmd[`FWEC_CMD_ONCE]) begin
        st.word_timeout_flag <= 1'b0;
        st.locked <= !write_ctrl[0] || st.invalid_location_flag;
      end
      if (op_refused) st.locked <= 1'b1;
      case (state)
        fwec_pkg::FWEC_IDLE: begin
          if (write_ctrl[0] && !st.invalid_location_flag) begin
            if (cmd[`FWEC_CMD_ERASE]) begin
              state <= fwec_pkg::FWEC_ERASE;
              st.busy <= 1'b1;
              st.erase_aborted_flag <= 1'b0;
            end else if (cmd[`FWEC_CMD_ONCE] || cmd[`FWEC_CMD_TRIG]) begin
              state <= fwec_pkg::FWEC_WRITE;
              multi <= cmd[`FWEC_CMD_TRIG];
              st.busy <= 1'b1;
            end
          end
        end
        fwec_pkg::FWEC_ERASE: begin
          if (cmd[`FWEC_CMD_ABORT] || (write_ctrl[1] && pend)) begin
            state <= fwec_pkg::FWEC_IDLE;
            st.busy <= 1'b0;
            st.erase_aborted_flag <= pend && write_ctrl[1];
          end else if (flash_done) begin
            state <= fwec_pkg::FWEC_IDLE;
            st.busy <= 1'b0;
            e_done <= 1'b1;
          end
        end
        fwec_pkg::FWEC_WRITE: begin
          if (flash_done) begin
            w_done <= 1'b1;
            tmo <= 32'h0000_0000;
            if (multi && !cmd[`FWEC_CMD_END]) begin
              state <= fwec_pkg::FWEC_WAIT;
              target <= next_target;
            end else begin
              state <= fwec_pkg::FWEC_IDLE;
              st.busy <= 1'b0;
              multi <= 1'b0;
            end
          end
        end
        fwec_pkg::FWEC_WAIT: begin
          tmo <= tmo + 32'h0000_0001;
          if (cmd[`FWEC_CMD_END]) begin
            state <= fwec_pkg::FWEC_IDLE;
            st.busy <= 1'b0;
            multi <= 1'b0;
          end else if (!st.word_ready_flag) begin
            state <= fwec_pkg::FWEC_WRITE;
          end else if (tmo >= 32'(TIMEOUT_CYC - 1)) begin
            state <= fwec_pkg::FWEC_IDLE;
            st.busy <= 1'b0;
            multi <= 1'b0;
            st.word_timeout_flag <= 1'b1;
          end
        end
        default: state <= fwec_pkg::FWEC_IDLE;
      endcase
    end
  end

  // Flash request outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_req <= '0;
    end else begin
      flash_req.req <= state == fwec_pkg::FWEC_ERASE ||
        state == fwec_pkg::FWEC_WRITE;
      flash_req.erase <= state == fwec_pkg::FWEC_ERASE;
      flash_req.addr <= state == fwec_pkg::FWEC_ERASE ?
        {loc_buf[31:PAGE_BITS], PAGE_BITS'(0)} :
        {target[31:2], 2'b00};
      flash_req.data <= word_buf;
    end
  end

  // Performance counters
  assign hit_ovf = st.counters_running_flag && cache_hit && &hits;
  assign miss_ovf = st.counters_running_flag && cache_miss && &misses;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hits <= '0;
      misses <= '0;
      st.counters_running_flag <= 1'b0;
    end else if (wr_mcmd && w_data[`FWEC_MC_START]) begin
      hits <= '0;
      misses <= '0;
      st.counters_running_flag <= 1'b1;
    end else if (wr_mcmd && w_data[`FWEC_MC_STOP]) begin
      st.counters_running_flag <= 1'b0;
    end else if (st.counters_running_flag) begin
      if (cache_hit) hits <= hits + 1'b1;
      if (cache_miss) misses <= misses + 1'b1;
      if (hit_ovf || miss_ovf) st.counters_running_flag <= 1'b0;
    end
  end

  // Interrupt flags, set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= 4'h0;
      irq <= 1'b0;
    end else begin
      flags <= (flags & ~((wr_go && aw_addr == `FWEC_OFF_IRQ_CLR) ?
        w_data[3:0] : 4'h0))
        | ((wr_go && aw_addr == `FWEC_OFF_IRQ_SET) ? w_data[3:0] : 4'h0)
        | {miss_ovf, hit_ovf, w_done, e_done};
      irq <= |(flags & irq_en);
    end
  end

  // Read channel
  always_comb begin
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    case (s_araddr)
      `FWEC_OFF_CTRL: rd_val = ctrl_reg;
      `FWEC_OFF_READ_SETUP: rd_val = read_setup_reg;
      `FWEC_OFF_WRITE_CTRL: rd_val = {30'h0, write_ctrl};
      `FWEC_OFF_LOC_BUF: rd_val = loc_buf;
      `FWEC_OFF_WORD_BUF: rd_val = word_buf;
      `FWEC_OFF_STATE: rd_val = {25'h0, st};
      `FWEC_OFF_IRQ_FLAGS: rd_val = {28'h0, flags};
      `FWEC_OFF_OP_CMD, `FWEC_OFF_IRQ_SET, `FWEC_OFF_IRQ_CLR,
      `FWEC_OFF_MISC_CMD: rd_val = 32'h0000_0000;
      `FWEC_OFF_IRQ_EN: rd_val = {28'h0, irq_en};
      `FWEC_OFF_LOCK: rd_val = {31'h0, cfg_locked};
      `FWEC_OFF_HITS: rd_val = {12'h0, hits};
      `FWEC_OFF_MISSES: rd_val = {12'h0, misses};
      `FWEC_OFF_TIMING: rd_val = timing_reg;
      default: rd_ok = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= 2'h0;
    end else if (s_rvalid) begin
      s_arready <= 1'b0;
      if (s_rready) s_rvalid <= 1'b0;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rd_val;
      s_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else begin
      s_arready <= 1'b1;
    end
  end

  a_word_ready_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && aw_addr == `FWEC_OFF_WORD_BUF |=> !st.word_ready_flag)
    else $error("word ready not cleared");
  a_lock_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_locked && wr_go && aw_addr == `FWEC_OFF_CTRL |=> $stable(ctrl_reg))
    else $error("locked write changed control");
  a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 irq == |($past(flags) & $past(irq_en)))
    else $error("irq mismatch");
  a_start_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_mcmd && w_data[`FWEC_MC_START] |=> hits == '0 && misses == '0
    && st.counters_running_flag)
    else $error("start not from zero");
  a_stop_halts: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_mcmd && w_data[`FWEC_MC_STOP] && !w_data[`FWEC_MC_START]
    |=> !st.counters_running_flag)
    else $error("stop ignored");
  a_busy_state: assert property (@(posedge aclk) disable iff (!aresetn)
    st.busy == (state != fwec_pkg::FWEC_IDLE))
    else $error("busy mismatch");
  a_no_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    state == fwec_pkg::FWEC_IDLE && !write_ctrl[0]
    |=> state == fwec_pkg::FWEC_IDLE)
    else $error("op without enable");
  a_load_ptr: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd[`FWEC_CMD_LOAD] |=> target == $past(loc_buf))
    else $error("pointer not loaded");
  a_set_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && aw_addr == `FWEC_OFF_IRQ_SET |=> (flags & $past(w_data[3:0]))
    == $past(w_data[3:0]))
    else $error("flag set lost");
endmodule : fwec_ctrl

/* File: rtl/fwec_defines.svh */
// Offsets, field positions, reset values and timing counts
`ifndef FWEC_DEFINES_SVH
`define FWEC_DEFINES_SVH
`define FWEC_OFF_CTRL 12'h000
`define FWEC_OFF_READ_SETUP 12'h004
`define FWEC_OFF_WRITE_CTRL 12'h008
`define FWEC_OFF_OP_CMD 12'h00C
`define FWEC_OFF_LOC_BUF 12'h010
`define FWEC_OFF_WORD_BUF 12'h018
`define FWEC_OFF_STATE 12'h01C
`define FWEC_OFF_IRQ_FLAGS 12'h02C
`define FWEC_OFF_IRQ_SET 12'h030
`define FWEC_OFF_IRQ_CLR 12'h034
`define FWEC_OFF_IRQ_EN 12'h038
`define FWEC_OFF_LOCK 12'h03C
`define FWEC_OFF_MISC_CMD 12'h040
`define FWEC_OFF_HITS 12'h044
`define FWEC_OFF_MISSES 12'h048
`define FWEC_OFF_TIMING 12'h050
`define FWEC_UNLOCK_KEY 16'h1B71
`define FWEC_CMD_LOAD 0
`define FWEC_CMD_ERASE 1
`define FWEC_CMD_END 2
`define FWEC_CMD_ONCE 3
`define FWEC_CMD_TRIG 4
`define FWEC_CMD_ABORT 5
`define FWEC_MC_START 1
`define FWEC_MC_STOP 2
`define FWEC_TIMEOUT_NS 30000
`define FWEC_CLK_NS 8
`define FWEC_TIMEOUT_CYC ((`FWEC_TIMEOUT_NS) / (`FWEC_CLK_NS))
`define FWEC_TIMING_RST 32'h0000_0010
`define FWEC_CNT_W 20
`endif

/* File: rtl/fwec_pkg.sv */
// Types for the flash write and erase controller
package fwec_pkg;
  typedef enum logic [1:0] {FWEC_IDLE, FWEC_ERASE, FWEC_WRITE, FWEC_WAIT}
    fwec_state_t;
  typedef struct packed {
    logic counters_running_flag;
    logic erase_aborted_flag;
    logic word_timeout_flag;
    logic word_ready_flag;
    logic invalid_location_flag;
    logic locked;
    logic busy;
  } fwec_status_t;
  typedef struct packed {
    logic req;
    logic erase;
    logic [31:0] addr;
    logic [31:0] data;
  } fwec_flash_req_t;
endpackage : fwec_pkg

/* File: sim/fwec_flash_model.sv */
// Flash array model that answers each request after a set delay
`timescale 1ns/1ps
module fwec_flash_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire fwec_pkg::fwec_flash_req_t flash_req,
  input wire logic [7:0] latency,
  output logic flash_done
);
  logic [7:0] cnt;
  // One done pulse per request, delay set by the bench
  always_ff @(posedge aclk) begin
    if (!aresetn || !flash_req.req || flash_done) begin
      cnt <= 8'h00;
      flash_done <= 1'b0;
    end else begin
      cnt <= cnt + 8'h01;
      flash_done <= (cnt == latency);
    end
  end
endmodule : fwec_flash_model

/* File: sim/tb.sv */
// Testbench for the flash write and erase controller
`timescale 1ns/1ps
`include "fwec_defines.svh"
module tb;
  localparam logic [11:0] st_a = `FWEC_OFF_STATE;
  localparam logic [11:0] op_a = `FWEC_OFF_OP_CMD;
  localparam logic [11:0] loc_a = `FWEC_OFF_LOC_BUF;
  localparam logic [11:0] fl_a = `FWEC_OFF_IRQ_FLAGS;
  localparam logic [11:0] wc_a = `FWEC_OFF_WRITE_CTRL;
  localparam logic [11:0] wd_a = `FWEC_OFF_WORD_BUF;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready;
  logic s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rr;
  fwec_pkg::fwec_flash_req_t flash_req;
  logic flash_done, cache_hit, cache_miss, irq_pending, irq;
  logic [7:0] lat;
  int n_fail;
  int n_checks;

  fwec_ctrl #(.TIMEOUT_CYC(20)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .flash_req(flash_req), .flash_done(flash_done),
    .cache_hit(cache_hit), .cache_miss(cache_miss),
    .irq_pending(irq_pending), .irq(irq));

  fwec_flash_model flash (.aclk(aclk), .aresetn(aresetn),
    .flash_req(flash_req), .latency(lat), .flash_done(flash_done));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %0t %s: %h", $time, m, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int t;
    logic aw, w, b;
    logic [1:0] br;
    t = 0;
    b = 1'b0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!b && t < 100) begin
      @(negedge aclk);
      aw = s_awvalid && s_awready;
      w = s_wvalid && s_wready;
      b = s_bvalid;
      br = s_bresp;
      @(posedge aclk);
      if (aw) s_awvalid <= 1'b0;
      if (w) s_wvalid <= 1'b0;
      t++;
    end
    chk({31'h0, b}, 32'h1, "write answer");
    chk({30'h0, br}, 32'h0, "write response");
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int t;
    logic ar, r;
    t = 0;
    r = 1'b0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    while (!r && t < 100) begin
      @(negedge aclk);
      ar = s_arvalid && s_arready;
      r = s_rvalid;
      d = s_rdata;
      rr = s_rresp;
      @(posedge aclk);
      if (ar) s_arvalid <= 1'b0;
      t++;
    end
    chk({31'h0, r}, 32'h1, "read answer");
  endtask : rd

  task automatic rc(input logic [11:0] a, input logic [31:0] k,
                    input logic [31:0] e, input string m);
    logic [31:0] d;
    rd(a, d);
    chk(d & k, e, m);
  endtask : rc

  task automatic wreq(input logic v);
    int t;
    t = 0;
    while (flash_req.req !== v && t < 200) begin
      @(posedge aclk);
      t++;
    end
    chk({31'h0, flash_req.req}, {31'h0, v}, "request level");
  endtask : wreq

  task automatic t_reset;
    logic [31:0] d;
    rc(st_a, 32'hFFFF_FFFF, 32'h0000_0008, "state");
    rc(fl_a, 32'hFFFF_FFFF, 32'h0, "flags");
    rc(`FWEC_OFF_IRQ_EN, 32'hFFFF_FFFF, 32'h0, "enable");
    rc(loc_a, 32'hFFFF_FFFF, 32'h0, "location");
    rc(wd_a, 32'hFFFF_FFFF, 32'h0, "word");
    rd(12'h014, d);
    chk({30'h0, rr}, 32'h2, "unmapped response");
    $display("reset test done");
  endtask : t_reset

  task automatic t_lock;
    wr(`FWEC_OFF_LOCK, 32'h0);
    rc(`FWEC_OFF_LOCK, 32'h1, 32'h1, "locked");
    wr(`FWEC_OFF_CTRL, 32'h0);
    rc(`FWEC_OFF_CTRL, 32'hFFFF_FFFF, 32'h1, "locked control");
    wr(op_a, 32'h2);
    rc(st_a, 32'h3, 32'h2, "lock abort");
    wr(`FWEC_OFF_LOCK, {16'h0, `FWEC_UNLOCK_KEY});
    rc(`FWEC_OFF_LOCK, 32'h1, 32'h0, "unlocked");
    $display("lock test done");
  endtask : t_lock

  task automatic t_erase;
    lat <= 8'h1E;
    wr(wc_a, 32'h0);
    wr(loc_a, 32'h0000_0234);
    wr(op_a, 32'h1);
    wr(op_a, 32'h2);
    rc(st_a, 32'h3, 32'h2, "erase refused");
    wr(wc_a, 32'h1);
    wr(op_a, 32'h2);
    wreq(1'b1);
    chk({31'h0, flash_req.erase}, 32'h1, "erase kind");
    chk(flash_req.addr, 32'h0000_0200, "page base");
    rc(st_a, 32'h3, 32'h1, "busy");
    wreq(1'b0);
    rc(st_a, 32'h1, 32'h0, "not busy");
    rc(fl_a, 32'h1, 32'h1, "erase flag");
    $display("erase test done");
  endtask : t_erase

  task automatic t_write;
    lat <= 8'h02;
    wr(`FWEC_OFF_IRQ_CLR, 32'hF);
    wr(loc_a, 32'h0000_0107);
    wr(op_a, 32'h1);
    wr(wd_a, 32'hA5A5_5A5A);
    rc(st_a, 32'h8, 32'h0, "word taken");
    wr(op_a, 32'h8);
    wreq(1'b1);
    chk(flash_req.addr, 32'h0000_0104, "word address");
    chk(flash_req.data, 32'hA5A5_5A5A, "word data");
    wreq(1'b0);
    rc(fl_a, 32'h3, 32'h2, "write flag");
    $display("write test done");
  endtask : t_write

  task automatic t_multi;
    wr(loc_a, 32'h0000_01FC);
    wr(op_a, 32'h1);
    wr(wd_a, 32'h1111_1111);
    wr(op_a, 32'h10);
    wreq(1'b1);
    chk(flash_req.addr, 32'h0000_01FC, "first word");
    wreq(1'b0);
    wr(wd_a, 32'h2222_2222);
    wreq(1'b1);
    chk(flash_req.addr, 32'h0, "wrapped word");
    wreq(1'b0);
    wr(op_a, 32'h4);
    rc(st_a, 32'h11, 32'h0, "ended");
    wr(wd_a, 32'h3333_3333);
    wr(op_a, 32'h10);
    wreq(1'b1);
    wreq(1'b0);
    repeat (30) @(posedge aclk);
    rc(st_a, 32'h11, 32'h10, "timed out");
    wr(op_a, 32'h8);
    rc(st_a, 32'h10, 32'h0, "timeout cleared");
    wreq(1'b0);
    $display("multiword test done");
  endtask : t_multi

  task automatic t_inval;
    wr(loc_a, 32'h0001_0000);
    wr(op_a, 32'h1);
    rc(st_a, 32'h4, 32'h4, "invalid location");
    $display("location test done");
  endtask : t_inval

  task automatic t_irq;
    wr(`FWEC_OFF_IRQ_CLR, 32'hF);
    wr(`FWEC_OFF_IRQ_SET, 32'h5);
    rc(fl_a, 32'hF, 32'h5, "set flags");
    for (int k = 0; k < 4; k++) begin
      wr(`FWEC_OFF_IRQ_EN, 32'h1 << k);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, {31'h0, !k[0]}, "irq line");
    end
    wr(`FWEC_OFF_IRQ_CLR, 32'h4);
    rc(fl_a, 32'hF, 32'h1, "clear one");
    wr(`FWEC_OFF_IRQ_SET, 32'h0);
    rc(fl_a, 32'hF, 32'h1, "zero set");
    wr(`FWEC_OFF_IRQ_CLR, 32'hF);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0, "irq dropped");
    $display("interrupt test done");
  endtask : t_irq

  task automatic t_count;
    wr(`FWEC_OFF_MISC_CMD, 32'h2);
    rc(st_a, 32'h40, 32'h40, "running");
    for (int i = 0; i < 3; i++) begin
      cache_hit <= 1'b1;
      cache_miss <= (i < 2);
      @(posedge aclk);
      cache_hit <= 1'b0;
      cache_miss <= 1'b0;
      @(posedge aclk);
    end
    rc(`FWEC_OFF_HITS, 32'hFFFF_FFFF, 32'h3, "hits");
    rc(`FWEC_OFF_MISSES, 32'hFFFF_FFFF, 32'h2, "misses");
    wr(`FWEC_OFF_MISC_CMD, 32'h4);
    rc(st_a, 32'h40, 32'h0, "stopped");
    cache_hit <= 1'b1;
    @(posedge aclk);
    cache_hit <= 1'b0;
    rc(`FWEC_OFF_HITS, 32'hFFFF_FFFF, 32'h3, "halted hits");
    wr(`FWEC_OFF_MISC_CMD, 32'h2);
    rc(`FWEC_OFF_HITS, 32'hFFFF_FFFF, 32'h0, "restart");
    $display("counter test done");
  endtask : t_count

  task automatic t_abort;
    lat <= 8'h3C;
    wr(loc_a, 32'h0000_0200);
    wr(op_a, 32'h1);
    rc(st_a, 32'h4, 32'h0, "location valid again");
    wr(wc_a, 32'h3);
    wr(op_a, 32'h2);
    wreq(1'b1);
    irq_pending <= 1'b1;
    wreq(1'b0);
    irq_pending <= 1'b0;
    rc(st_a, 32'h21, 32'h20, "erase aborted");
    $display("abort test done");
  endtask : t_abort

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    #100000;
    n_fail++;
    $display("unexpected %0t watchdog expired", $time);
    complete_run;
  end

  initial begin
    aresetn = 1'b0;
    s_awaddr = 12'h000;
    s_awvalid = 1'b0;
    s_wdata = 32'h0;
    s_wstrb = 4'hF;
    s_wvalid = 1'b0;
    s_bready = 1'b1;
    s_araddr = 12'h000;
    s_arvalid = 1'b0;
    s_rready = 1'b1;
    cache_hit = 1'b0;
    cache_miss = 1'b0;
    irq_pending = 1'b0;
    lat = 8'h04;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_lock;
    t_erase;
    t_write;
    t_multi;
    t_inval;
    t_irq;
    t_count;
    t_abort;
    complete_run;
  end
endmodule : tb
